/* File: src/macrocell_pkg.sv */
// shared constants, register map and mode type for the macrocell array
// assumes one clock domain and a 32-bit apb slave in front of the array
package macrocell_pkg;

  // array geometry
  localparam int NUM_CELLS      = 8;   // output macrocells
  localparam int TERMS_PER_CELL = 8;   // product terms per macrocell
  localparam int NUM_DED        = 8;   // dedicated input pins
  localparam int NUM_LINES      = 16;  // array lines: dedicated inputs plus feedback slots
  localparam int TERM_W         = 32;  // true and complement literal per line
  localparam int NUM_TERMS      = NUM_CELLS * TERMS_PER_CELL;
  localparam int TERM_IDX_W     = 6;   // index into the product term store

  // macrocell positions with special routing
  localparam int OUTER_LO      = 0;    // outermost cell next to the enable pin
  localparam int OUTER_HI      = 7;    // outermost cell next to the clock pin
  localparam int CENTRE_LO     = 3;    // centre pair
  localparam int CENTRE_HI     = 4;
  localparam int SLEEP_IN_IDX  = 2;    // dedicated input that doubles as sleep control

  // apb register map, byte addresses
  localparam int              ADDR_W         = 12;
  localparam logic [11:0]     ADDR_MODE      = 12'h000;
  localparam logic [11:0]     ADDR_CELL      = 12'h004;
  localparam logic [11:0]     ADDR_STATUS    = 12'h008;
  localparam int              TERM_PAGE_LSB  = 8;
  localparam logic [3:0]      TERM_PAGE      = 4'h1;     // 0x100..0x1FC
  localparam int              TERM_IDX_LSB   = 2;

  // mode register fields
  localparam int MODE_LSB  = 0;
  localparam int PD_EN_BIT = 2;
  localparam int RUN_BIT   = 3;

  // cell register fields
  localparam int CELL_REG_LSB   = 0;
  localparam int CELL_INPUT_LSB = 8;
  localparam int CELL_POL_LSB   = 16;

  // status register fields
  localparam int STAT_OUT_LSB   = 0;
  localparam int STAT_OE_LSB    = 8;
  localparam int STAT_REG_LSB   = 16;
  localparam int STAT_SLEEP_BIT = 24;

  // architecture modes; the fourth code is illegal
  typedef enum logic [1:0] {
    MODE_REGISTERED,
    MODE_COMPLEX,
    MODE_SIMPLE
  } mode_t;
  localparam logic [1:0] MODE_ILLEGAL = 2'h3;

  // reset values
  localparam mode_t                 MODE_RST   = MODE_REGISTERED;
  localparam logic                  PD_EN_RST  = 1'b0;
  localparam logic                  RUN_RST    = 1'b0;
  localparam logic [NUM_CELLS-1:0]  CELL_RST   = 8'h00;
  localparam logic [TERM_W-1:0]     TERM_RST   = 32'h0000_0000;
  localparam logic [NUM_CELLS-1:0]  REG_RST    = 8'h00;
  localparam logic [NUM_CELLS-1:0]  OUT_RST    = 8'hFF;
  localparam logic [NUM_CELLS-1:0]  OE_RST     = 8'h00;
  localparam logic [NUM_LINES-1:0]  LINES_RST  = 16'h0000;

  // one product term: and of every selected literal; no literal selected reads low
  function automatic logic term_hit(input logic [TERM_W-1:0]    w,
                                    input logic [NUM_LINES-1:0] l);
    logic [TERM_W-1:0] lit;
    lit = '0;
    for (int k = 0; k < NUM_LINES; k++) begin
      lit[2*k]   = l[k];
      lit[2*k+1] = ~l[k];
    end
    return (|w) && ((w & ~lit) == '0);
  endfunction

endpackage

/* File: src/macrocell_slice.sv */
// one output macrocell: product terms, sum term, enable and polarity
// assumes the array lines and the register value come from the top level
module macrocell_slice #(
  parameter bit CENTRE = 1'b0              // centre cell, always driving in simple mode
) (
  // static configuration
  input  macrocell_pkg::mode_t                                         mode,
  input  logic                                                         is_reg,
  input  logic                                                         is_input,
  input  logic                                                         polarity,
  // array
  input  logic [macrocell_pkg::NUM_LINES-1:0]                          lines,
  input  logic [macrocell_pkg::TERMS_PER_CELL*macrocell_pkg::TERM_W-1:0] terms,
  // shared pin and register state
  input  logic                                                         oe_pin_n,
  input  logic                                                         reg_q,
  // results
  output logic                                                         reg_d,
  output logic                                                         drive_en,
  output logic                                                         drive_val
);
  import macrocell_pkg::*;

  logic [TERMS_PER_CELL-1:0] pt;          // evaluated product terms
  logic                      sum_all;     // or of all eight terms
  logic                      sum_seven;   // or of terms 1..7, term 0 kept for enable

  // product term evaluation, one per stored word
  always_comb begin
    for (int t = 0; t < TERMS_PER_CELL; t++) begin
      pt[t] = term_hit(terms[t*TERM_W +: TERM_W], lines);
    end
    sum_all   = |pt;
    sum_seven = |pt[TERMS_PER_CELL-1:1];
  end

  // per-mode behaviour of the cell
  always_comb begin
    reg_d     = reg_q;
    drive_en  = 1'b0;
    drive_val = 1'b0;
    unique case (mode)
      MODE_REGISTERED: begin
        if (is_input) begin
          // pin only feeds the array
          drive_en = 1'b0;
        end else if (is_reg) begin
          // all eight terms into the register, shared active-low enable
          reg_d     = sum_all;
          drive_en  = ~oe_pin_n;
          drive_val = ~reg_q;
        end else begin
          // term 0 enables, seven terms form the output
          drive_en  = pt[0];
          drive_val = sum_seven ^ polarity;
        end
      end
      MODE_COMPLEX: begin
        drive_en  = pt[0];
        drive_val = sum_seven ^ polarity;
      end
      MODE_SIMPLE: begin
        // centre pair ignores the input choice and always drives
        drive_en  = CENTRE | ~is_input;
        drive_val = sum_all ^ polarity;
      end
      default: begin
        // illegal code: keep the pin released
        drive_en  = 1'b0;
      end
    endcase
  end

endmodule

/* File: src/programmable_macrocell_array.sv */
// top of the configurable macrocell array with its apb configuration slave
// assumes all pins are synchronous to clk_sys; the bench resolves io levels
//
// Contract
// - registered mode: pin1 clock, pin11 enable only
// - complex mode: pins 1/11 use outer feedback
// - simple mode: neighbour feedback, centre pair always drives
// - registered mode cells: registered, combinatorial or input
// - registered cell: clock pin, enable pin, eight terms
// - combinatorial cell: term enable, seven sum terms
// - input cell never drives its pin
// - complex mode: inner six cells feed pins back
// - complex mode: outer cells are outputs only
// - complex mode: seven sum terms plus enable term
// - simple mode: eight terms, input or output
// - simple mode: clock and enable pins plain inputs
// - sleep enabled: sleep pin leaves the array
// - sleeping: hold all state, block other inputs
// - registers reset low, registered outputs read high
//
// Chosen here: the address map and the APB slave port.
module programmable_macrocell_array (
  // clock and reset
  input  logic                                    clk_sys,
  input  logic                                    rst,
  // apb slave
  input  logic                                    psel,
  input  logic                                    penable,
  input  logic                                    pwrite,
  input  logic [macrocell_pkg::ADDR_W-1:0]        paddr,
  input  logic [31:0]                             pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // shared pins
  input  logic                                    clk_pin,
  input  logic                                    oe_pin_n,
  input  logic [macrocell_pkg::NUM_DED-1:0]       ded_in,
  // macrocell pins
  input  logic [macrocell_pkg::NUM_CELLS-1:0]     io_in,
  output logic [macrocell_pkg::NUM_CELLS-1:0]     io_out,
  output logic [macrocell_pkg::NUM_CELLS-1:0]     io_oe
);
  import macrocell_pkg::*;

  // configuration state
  mode_t                  mode_q,       mode_d;        // architecture mode
  logic                   pd_en_q,      pd_en_d;       // sleep option selected
  logic                   run_q,        run_d;         // array live, config locked
  logic [NUM_CELLS-1:0]   cell_reg_q,   cell_reg_d;    // cell is registered
  logic [NUM_CELLS-1:0]   cell_input_q, cell_input_d;  // cell is a dedicated input
  logic [NUM_CELLS-1:0]   cell_pol_q,   cell_pol_d;    // invert combinatorial output
  logic [TERM_W-1:0]      term_q [NUM_TERMS];          // product term store
  logic [TERM_W-1:0]      term_d [NUM_TERMS];

  // array state
  logic [NUM_LINES-1:0]   lines_q,      lines_d;       // captured array lines
  logic                   clk_prev_q,   clk_prev_d;    // clock pin, one cycle late
  logic [NUM_CELLS-1:0]   reg_state_q,  reg_state_d;   // macrocell registers
  logic [NUM_CELLS-1:0]   io_out_q,     io_out_d;      // pin drive values
  logic [NUM_CELLS-1:0]   io_oe_q,      io_oe_d;       // pin drive enables

  // apb answer state
  logic [31:0]            prdata_q,     prdata_d;
  logic                   pready_q,     pready_d;
  logic                   pslverr_q,    pslverr_d;

  // combinational helpers
  logic                   setup_w;      // apb setup cycle
  logic                   wr_w;         // write takes effect this edge
  logic                   hit_mode, hit_cell, hit_status, hit_term, mapped;
  logic [TERM_IDX_W-1:0]  term_idx;     // product term word index
  logic [31:0]            rd_val;       // read data for the decoded register
  logic                   sleep_w;      // sleeping this cycle
  logic                   clk_rise_w;   // rising edge seen on the clock pin
  logic [NUM_DED-1:0]     ded_w;        // dedicated inputs as the array sees them
  logic [NUM_CELLS-1:0]   fb_w;         // feedback slots
  logic [NUM_CELLS-1:0]   slice_reg_d;  // next register value per cell
  logic [NUM_CELLS-1:0]   slice_en;     // drive enable per cell
  logic [NUM_CELLS-1:0]   slice_val;    // drive value per cell
  logic                   probe_hit_w;  // enable term of cell 1, for checking only

  // outputs straight from flops
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign io_out  = io_out_q;
  assign io_oe   = io_oe_q;

  // address decode, held stable by the master through the access phase
  assign setup_w    = psel & ~penable;
  assign hit_mode   = (paddr == ADDR_MODE);
  assign hit_cell   = (paddr == ADDR_CELL);
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_term   = (paddr[ADDR_W-1:TERM_PAGE_LSB] == TERM_PAGE) && (paddr[1:0] == 2'h0);
  assign mapped     = hit_mode | hit_cell | hit_status | hit_term;
  assign term_idx   = paddr[TERM_IDX_LSB +: TERM_IDX_W];
  assign wr_w       = psel & penable & pready_q & pwrite & ~pslverr_q;

  // read mux; reserved bits read as zero
  always_comb begin
    rd_val = '0;
    if (hit_mode) begin
      rd_val[MODE_LSB +: 2] = mode_q;
      rd_val[PD_EN_BIT]     = pd_en_q;
      rd_val[RUN_BIT]       = run_q;
    end else if (hit_cell) begin
      rd_val[CELL_REG_LSB +: NUM_CELLS]   = cell_reg_q;
      rd_val[CELL_INPUT_LSB +: NUM_CELLS] = cell_input_q;
      rd_val[CELL_POL_LSB +: NUM_CELLS]   = cell_pol_q;
    end else if (hit_status) begin
      // live pin and register state
      rd_val[STAT_OUT_LSB +: NUM_CELLS] = io_out_q;
      rd_val[STAT_OE_LSB +: NUM_CELLS]  = io_oe_q;
      rd_val[STAT_REG_LSB +: NUM_CELLS] = reg_state_q;
      rd_val[STAT_SLEEP_BIT]            = sleep_w;
    end else if (hit_term) begin
      rd_val = term_q[term_idx];
    end
  end

  // apb answer: one wait-free access phase after every setup
  always_comb begin
    pready_d  = setup_w;
    pslverr_d = setup_w & ~mapped;
    prdata_d  = (setup_w && !pwrite && mapped) ? rd_val : 32'h0000_0000;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // configuration writes; while running only the run bit may change
  always_comb begin
    mode_d       = mode_q;
    pd_en_d      = pd_en_q;
    run_d        = run_q;
    cell_reg_d   = cell_reg_q;
    cell_input_d = cell_input_q;
    cell_pol_d   = cell_pol_q;
    if (wr_w && hit_mode) begin
      run_d = pwdata[RUN_BIT];
      if (!run_q) begin
        pd_en_d = pwdata[PD_EN_BIT];
        // an illegal mode code leaves the mode as it was
        if (pwdata[MODE_LSB +: 2] != MODE_ILLEGAL) begin
          mode_d = mode_t'(pwdata[MODE_LSB +: 2]);
        end
      end
    end
    if (wr_w && hit_cell && !run_q) begin
      cell_reg_d   = pwdata[CELL_REG_LSB +: NUM_CELLS];
      cell_input_d = pwdata[CELL_INPUT_LSB +: NUM_CELLS];
      cell_pol_d   = pwdata[CELL_POL_LSB +: NUM_CELLS];
    end
  end

  // product term store writes, locked while running
  always_comb begin
    term_d = term_q;
    if (wr_w && hit_term && !run_q) begin
      term_d[term_idx] = pwdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q       <= MODE_RST;
      pd_en_q      <= PD_EN_RST;
      run_q        <= RUN_RST;
      cell_reg_q   <= CELL_RST;
      cell_input_q <= CELL_RST;
      cell_pol_q   <= CELL_RST;
      for (int i = 0; i < NUM_TERMS; i++) begin
        term_q[i] <= TERM_RST;
      end
    end else begin
      mode_q       <= mode_d;
      pd_en_q      <= pd_en_d;
      run_q        <= run_d;
      cell_reg_q   <= cell_reg_d;
      cell_input_q <= cell_input_d;
      cell_pol_q   <= cell_pol_d;
      term_q       <= term_d;
    end
  end

  // sleep and clock edge; inputs are already synchronous, no synchroniser
  assign sleep_w    = pd_en_q & ded_in[SLEEP_IN_IDX];
  assign clk_rise_w = clk_pin & ~clk_prev_q;

  // array line routing per mode
  always_comb begin
    ded_w = ded_in;
    // the sleep pin is a control, not a logic input, once selected
    if (pd_en_q) begin
      ded_w[SLEEP_IN_IDX] = 1'b0;
    end
    fb_w = '0;
    for (int c = 0; c < NUM_CELLS; c++) begin
      unique case (mode_q)
        MODE_REGISTERED: begin
          // clock and enable pins have no array path here
          fb_w[c] = cell_reg_q[c] ? reg_state_q[c] : io_in[c];
        end
        MODE_COMPLEX: begin
          if (c == OUTER_LO) begin
            fb_w[c] = oe_pin_n;
          end else if (c == OUTER_HI) begin
            fb_w[c] = clk_pin;
          end else begin
            fb_w[c] = io_in[c];
          end
        end
        MODE_SIMPLE: begin
          // each slot reads the next pin outward; centre pins are never read
          if (c == OUTER_LO) begin
            fb_w[c] = oe_pin_n;
          end else if (c == OUTER_HI) begin
            fb_w[c] = clk_pin;
          end else if (c < CENTRE_HI) begin
            fb_w[c] = io_in[c-1];
          end else begin
            fb_w[c] = io_in[c+1];
          end
        end
        default: begin
          fb_w[c] = 1'b0;
        end
      endcase
    end
  end

  // one slice per macrocell
  for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
    logic [TERMS_PER_CELL*TERM_W-1:0] cell_terms;   // this cell's eight words
    for (genvar t = 0; t < TERMS_PER_CELL; t++) begin : g_term
      assign cell_terms[t*TERM_W +: TERM_W] = term_q[c*TERMS_PER_CELL+t];
    end
    macrocell_slice #(
      .CENTRE ((c == CENTRE_LO) || (c == CENTRE_HI))
    ) u_slice (
      .mode      (mode_q),
      .is_reg    (cell_reg_q[c]),
      .is_input  (cell_input_q[c]),
      .polarity  (cell_pol_q[c]),
      .lines     (lines_q),
      .terms     (cell_terms),
      .oe_pin_n  (oe_pin_n),
      .reg_q     (reg_state_q[c]),
      .reg_d     (slice_reg_d[c]),
      .drive_en  (slice_en[c]),
      .drive_val (slice_val[c])
    );
  end

  // array state: sleep freezes everything, including the clock pin history
  always_comb begin
    lines_d     = lines_q;
    clk_prev_d  = clk_prev_q;
    reg_state_d = reg_state_q;
    io_out_d    = io_out_q;
    io_oe_d     = io_oe_q;
    if (!sleep_w) begin
      lines_d    = {fb_w, ded_w};
      clk_prev_d = clk_pin;
      if (!run_q) begin
        // stopped: registers low, so registered pins would read high
        reg_state_d = REG_RST;
        io_out_d    = OUT_RST;
        io_oe_d     = OE_RST;
      end else begin
        for (int c = 0; c < NUM_CELLS; c++) begin
          // only registered mode gives the clock pin a clock function
          if (mode_q == MODE_REGISTERED && cell_reg_q[c] && clk_rise_w) begin
            reg_state_d[c] = slice_reg_d[c];
          end
        end
        io_out_d = slice_val;
        io_oe_d  = slice_en;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lines_q     <= LINES_RST;
      clk_prev_q  <= 1'b0;
      reg_state_q <= REG_RST;
      io_out_q    <= OUT_RST;
      io_oe_q     <= OE_RST;
    end else begin
      lines_q     <= lines_d;
      clk_prev_q  <= clk_prev_d;
      reg_state_q <= reg_state_d;
      io_out_q    <= io_out_d;
      io_oe_q     <= io_oe_d;
    end
  end

  // checking helper: enable term of cell 1 against the captured lines
  assign probe_hit_w = term_hit(term_q[TERMS_PER_CELL], lines_q);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // running and awake in registered mode
  sequence live_reg_s;
    run_q && !sleep_w && mode_q == MODE_REGISTERED;
  endsequence

  sequence reg_edge_s;
    live_reg_s ##0 cell_reg_q[0] && !cell_input_q[0] && clk_rise_w;
  endsequence

  AST_REG_FB_NOT_PIN: assert property (
    live_reg_s |=> lines_q[NUM_DED+OUTER_HI] ==
      $past(cell_reg_q[OUTER_HI] ? reg_state_q[OUTER_HI] : io_in[OUTER_HI]))
    else $error("registered mode feedback slot took the wrong source");

  AST_COMPLEX_OUTER_FB: assert property (
    (mode_q == MODE_COMPLEX && !sleep_w) |=>
      lines_q[NUM_DED+OUTER_LO] == $past(oe_pin_n) &&
      lines_q[NUM_DED+OUTER_HI] == $past(clk_pin))
    else $error("complex mode outer slots not fed from shared pins");

  AST_SIMPLE_CENTRE_ON: assert property (
    (run_q && !sleep_w && mode_q == MODE_SIMPLE) |=>
      io_oe_q[CENTRE_LO] && io_oe_q[CENTRE_HI])
    else $error("centre pair not driving in simple mode");

  AST_REG_CAPTURE: assert property (
    reg_edge_s |=> (reg_state_q[0] == $past(slice_reg_d[0])) ##1
      ($past(sleep_w) || io_out_q[0] == !$past(reg_state_q[0]) || !$past(run_q)))
    else $error("register did not capture on clock pin edge");

  AST_REG_SHARED_OE: assert property (
    (live_reg_s ##0 cell_reg_q[0] && !cell_input_q[0]) |=> io_oe_q[0] == !$past(oe_pin_n))
    else $error("registered output enable not from shared pin");

  AST_COMPLEX_TERM_OE: assert property (
    (run_q && !sleep_w && mode_q == MODE_COMPLEX) |=> io_oe_q[1] == $past(probe_hit_w))
    else $error("complex mode enable not from its product term");

  AST_INPUT_OFF: assert property (
    (live_reg_s ##0 cell_input_q[2]) |=> !io_oe_q[2])
    else $error("input cell drives its pin");

  AST_SLEEP_LINE_ZERO: assert property (
    (pd_en_q && !sleep_w) |=> !lines_q[SLEEP_IN_IDX])
    else $error("sleep pin reached the array");

  AST_SLEEP_HOLD: assert property (
    sleep_w |=> $stable(io_out_q) && $stable(io_oe_q) && $stable(reg_state_q) &&
      $stable(lines_q))
    else $error("state changed while sleeping");

  AST_STOPPED_HIGH: assert property (
    (!run_q && !sleep_w) |=> reg_state_q == REG_RST && io_out_q == OUT_RST && io_oe_q == OE_RST)
    else $error("stopped array not cleared");

  AST_NO_CLOCK_FN: assert property (
    (mode_q != MODE_REGISTERED) |=> $stable(reg_state_q))
    else $error("register moved outside registered mode");

  AST_CONFIG_LOCKED: assert property (
    run_q |=> $stable(mode_q) && $stable(pd_en_q) && $stable(cell_reg_q) &&
      $stable(cell_input_q) && $stable(cell_pol_q))
    else $error("configuration changed while running");

endmodule

/* File: tb/board_model.sv */
// board model: resolves the macrocell pin levels that the device sees
// assumes the device drive wins; a pin nobody drives keeps its last level
module board_model
  import macrocell_pkg::*;
(
  // clock and drive sides
  input  logic                 clk_sys,
  input  logic [NUM_CELLS-1:0] io_out,
  input  logic [NUM_CELLS-1:0] io_oe,
  input  logic [NUM_CELLS-1:0] drv_en,
  input  logic [NUM_CELLS-1:0] drv_val,
  // resolved level
  output logic [NUM_CELLS-1:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_CELLS-1:0] keep_q = '0;  // keeper level, weak hold
  // keeper tracks the pin so a released pin never floats
  always_ff @(posedge clk_sys) begin
    keep_q <= io_in;
  end
  // device first, then board, then keeper
  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      io_in[i] = io_oe[i] ? io_out[i] : (drv_en[i] ? drv_val[i] : keep_q[i]);
    end
  end
endmodule

/* File: tb/tb_programmable_macrocell_array.sv */
// bench for the macrocell array: apb set-up, pin stimulus, checks
// assumes board_model resolves the macrocell pins
module tb_programmable_macrocell_array;
  import macrocell_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, ok, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic        clk_pin, oe_pin_n;
  logic [7:0]  ded_in, io_in, io_out, io_oe;
  int          failures = 0;
  int          comparisons = 0;
  // device and board
  programmable_macrocell_array programmable_macrocell_array_inst (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_pin(clk_pin), .oe_pin_n(oe_pin_n), .ded_in(ded_in),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  board_model board_model_inst (
    .clk_sys(clk_sys), .io_out(io_out), .io_oe(io_oe), .drv_en(8'h00),
    .drv_val(8'h00), .io_in(io_in));
  // 40 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    ok = 1'b0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge clk_sys);
      ok = (pready === 1'b1);
    end while (!ok);
    err    = pslverr;
    rd_val = wr ? {31'h0, pslverr} : prdata;  // writes keep only the error flag
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // pin levels, then time for sampling and output registers
  task automatic pins(input logic [7:0] d, input logic ck, input logic oen);
    @(posedge clk_sys);
    ded_in   <= d;
    clk_pin  <= ck;
    oe_pin_n <= oen;
    repeat (4) @(posedge clk_sys);
  endtask
  // end of run
  task automatic print_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 130 cycles needed
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clk_pin = 1'b0;
    oe_pin_n = 1'b1;
    ded_in = 8'h00;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    chk("pins", {16'h0, io_oe, io_out}, 32'h00FF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd_val, 32'h0000_00FF);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    // registered mode: cell0 registered on term 7, cell1 comb, cell2 input
    apb(1'b1, ADDR_CELL, 32'h0000_0401);
    apb(1'b1, 12'h11C, 32'h0000_0001);
    apb(1'b1, 12'h120, 32'h0000_0004);
    apb(1'b1, 12'h13C, 32'h0000_0001);
    apb(1'b1, 12'h140, 32'h0000_0001);
    apb(1'b1, ADDR_MODE, 32'h0000_0008);
    pins(8'h03, 1'b0, 1'b0);
    pins(8'h03, 1'b1, 1'b0);
    chk("reg oe", {24'h0, io_oe}, 32'h03);
    chk("reg out", {30'h0, io_out[1:0]}, 32'h2);
    pins(8'h00, 1'b1, 1'b1);
    chk("no rise", {22'h0, io_oe[1:0], 6'h0, io_out[1:0]}, 32'h0);
    pins(8'h00, 1'b0, 1'b0);
    pins(8'h00, 1'b1, 1'b0);
    chk("rise", {31'h0, io_out[0]}, 32'h1);
    apb(1'b1, ADDR_CELL, 32'h0);
    apb(1'b0, ADDR_CELL, 32'h0);
    chk("cell locked", rd_val, 32'h0000_0401);
    // stop, then complex mode with the clock pin as a plain input
    apb(1'b1, ADDR_MODE, 32'h0);
    pins(8'h00, 1'b0, 1'b0);
    chk("stopped", {16'h0, io_oe, io_out}, 32'h00FF);
    // the unused fourth mode code must leave the mode as it was
    apb(1'b1, ADDR_MODE, 32'h3);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk("illegal mode", rd_val, 32'h0);
    apb(1'b1, ADDR_MODE, 32'h1);
    apb(1'b1, 12'h124, 32'h4000_0000);
    apb(1'b1, ADDR_MODE, 32'h9);
    pins(8'h02, 1'b1, 1'b1);
    chk("cplx hi", {16'h0, io_oe, io_out} & 32'h0303, 32'h0202);
    pins(8'h02, 1'b0, 1'b1);
    chk("cplx lo", {16'h0, io_oe, io_out} & 32'h0303, 32'h0200);
    // simple mode: centre pair always drives, cell2 stays an input
    apb(1'b1, ADDR_MODE, 32'h0);
    apb(1'b1, ADDR_MODE, 32'hA);
    pins(8'h00, 1'b1, 1'b1);
    chk("simple oe", {24'h0, io_oe}, 32'hFB);
    chk("simple out", {31'h0, io_out[1]}, 32'h1);
    // sleep: outputs frozen while the sleep pin is high
    apb(1'b1, ADDR_MODE, 32'h0);
    apb(1'b1, ADDR_MODE, 32'hE);
    pins(8'h01, 1'b0, 1'b1);
    pins(8'h05, 1'b0, 1'b1);
    pins(8'h04, 1'b0, 1'b1);
    chk("asleep", {31'h0, io_out[1]}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("sleep flag", {31'h0, rd_val[STAT_SLEEP_BIT]}, 32'h1);
    pins(8'h00, 1'b0, 1'b1);
    chk("awake", {31'h0, io_out[1]}, 32'h0);
    print_verdict();
  end
endmodule
